// *** src/twm_params.svh ***
// register map, field positions and reset values of the two-wire master
// assumes 32-bit AHB-Lite data, one aligned word per register
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

`define TWM_OFS_CTRL     5'h00
`define TWM_OFS_MODE     5'h04
`define TWM_OFS_CLKDIV   5'h08
`define TWM_OFS_STATUS   5'h0C
`define TWM_OFS_MASK     5'h10
`define TWM_OFS_TXHOLD   5'h14
`define TWM_OFS_RXHOLD   5'h18

`define TWM_CR_START     0
`define TWM_CR_MSEN      1
`define TWM_CR_MASTER_DISABLE_BIT     2
`define TWM_CR_SWRST     7

`define TWM_SR_TRANSFER_COMPLETE_FLAG    0
`define TWM_SR_RECEIVE_READY_FLAG     1
`define TWM_SR_TRANSMIT_READY_FLAG     2
`define TWM_SR_OVRE      3
`define TWM_SR_NACK      4
`define TWM_SR_BUSY      8
`define TWM_SR_STUCK     9

`define TWM_MODE_DIR     8
`define TWM_MODE_CNT_LSB 16

`define TWM_CLK_HI_LSB   8
`define TWM_CLK_EXP_LSB  16

`define TWM_RST_LODIV    8'h04
`define TWM_RST_HIDIV    8'h04
`define TWM_RST_EXP      3'h0
`define TWM_RST_TRANSFER_COMPLETE_FLAG   1'b1
`define TWM_RST_TRANSMIT_READY_FLAG    1'b1
`define TWM_PERIOD_MAX   13'h1FFF

`endif

// *** src/twm_pkg.sv ***
// types shared by the two-wire master
// assumes nothing beyond a SystemVerilog compiler
package twm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_LOW,
    ST_HIGH,
    ST_STOP_LOW,
    ST_STOP_HIGH
  } twm_state_t;

endpackage

// *** src/twm_master.sv ***
// two-wire master with AHB-Lite register slave and status quirks
// assumes external pull-ups on both lines and a single AHB-Lite master
`include "twm_params.svh"

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - writing master disable freezes a running transfer at once
// - master disable leaves transfer-complete and transmit-ready untouched
// - not-acknowledge and transfer-complete rise in the same cycle
// - reading the status register clears not-acknowledge
// - status read between nack and completion loses the nack flag
// - receive holding register loads on every byte, transmit bytes too
// - transmit overwrite raises neither receive-ready nor overrun
// - software reset mid-frame with clock low blocks later transfers until a bus reset
module twm_master
  import twm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);

  // period in system clocks; wraps above 8191, software must not go there
  function automatic logic [12:0] twm_period(input logic [7:0] div,
                                              input logic [2:0] ex);
    logic [12:0] p;
    p = 13'(div) << ex;
    twm_period = (p == 13'h0000) ? 13'h0001 : p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state on every access

  logic        ph_ff;
  logic        w_ff;
  logic [4:0]  a_ff;
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  wire         accept = hsel & htrans[1] & hready;
  wire         wr     = ph_ff & w_ff;
  wire         rd     = ph_ff & ~w_ff;
  wire         wr_cr  = wr & (a_ff == `TWM_OFS_CTRL);
  wire         wr_sr  = wr & (a_ff == `TWM_OFS_STATUS);
  wire         rd_sr  = rd & (a_ff == `TWM_OFS_STATUS);
  wire         rd_rhr = rd & (a_ff == `TWM_OFS_RXHOLD);
  wire         wr_thr = wr & (a_ff == `TWM_OFS_TXHOLD);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_ff        <= 1'b0;
      w_ff         <= 1'b0;
      a_ff         <= 5'h00;
      hreadyout_ff <= 1'b1;
    end
    else
    begin
      ph_ff        <= accept;
      hreadyout_ff <= ~accept;
      if (accept)
      begin
        w_ff <= hwrite;
        a_ff <= haddr[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line synchronisers

  logic scl_s1_ff, scl_s2_ff, sda_s1_ff, sda_s2_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end
    else
    begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration

  logic       en_ff, dir_ff, stuck_ff;
  logic [6:0] addr_ff;
  logic [7:0] nbytes_ff, lodiv_ff, hidiv_ff, thr_ff;
  logic [2:0] exp_ff;
  logic [4:0] imr_ff;
  twm_state_t st_ff;
  wire        swrst = wr_cr & hwdata[`TWM_CR_SWRST];
  wire        busy  = (st_ff != ST_IDLE);
  wire [12:0] lo_per = twm_period(lodiv_ff, exp_ff);
  wire [12:0] hi_per = twm_period(hidiv_ff, exp_ff);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_ff     <= 1'b0;
      dir_ff    <= 1'b0;
      addr_ff   <= 7'h00;
      nbytes_ff <= 8'h00;
      lodiv_ff  <= `TWM_RST_LODIV;
      hidiv_ff  <= `TWM_RST_HIDIV;
      exp_ff    <= `TWM_RST_EXP;
      imr_ff    <= 5'h00;
      thr_ff    <= 8'h00;
      stuck_ff  <= 1'b0;
    end
    else
    begin
      // disable wins over enable in the same write
      if (wr_cr & hwdata[`TWM_CR_MSEN])
        en_ff <= 1'b1;
      if ((wr_cr & hwdata[`TWM_CR_MASTER_DISABLE_BIT]) | swrst)
        en_ff <= 1'b0;
      // only a bus reset recovers from this
      if (swrst & busy & ~scl_s2_ff)
        stuck_ff <= 1'b1;
      if (wr & (a_ff == `TWM_OFS_MODE))
      begin
        addr_ff   <= hwdata[6:0];
        dir_ff    <= hwdata[`TWM_MODE_DIR];
        nbytes_ff <= hwdata[`TWM_MODE_CNT_LSB +: 8];
      end
      if (wr & (a_ff == `TWM_OFS_CLKDIV))
      begin
        lodiv_ff <= hwdata[7:0];
        hidiv_ff <= hwdata[`TWM_CLK_HI_LSB +: 8];
        exp_ff   <= hwdata[`TWM_CLK_EXP_LSB +: 3];
      end
      if (wr & (a_ff == `TWM_OFS_MASK))
        imr_ff <= hwdata[4:0];
      if (wr_thr)
        thr_ff <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  logic [12:0] cnt_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  sh_ff, left_ff;
  logic        first_ff, scl_oe_ff, sda_oe_ff;
  wire ack_slot  = (bit_ff == 4'h8);
  wire tx_byte   = first_ff | ~dir_ff;
  wire nack_seen = tx_byte & sda_s2_ff;
  wire go        = wr_cr & hwdata[`TWM_CR_START] & en_ff & ~stuck_ff & ~busy & ~swrst;
  wire hi_end    = (st_ff == ST_HIGH) & en_ff & scl_s2_ff & (cnt_ff == 13'h0000) & ~swrst;
  wire byte_done = hi_end & ack_slot;
  wire load_next = byte_done & ~nack_seen & (left_ff != 8'h00);
  wire frame_end = (st_ff == ST_STOP_HIGH) & en_ff & scl_s2_ff
                   & (cnt_ff == 13'h0000) & ~swrst;
  // master acks every received byte but the last
  wire drive_low = ack_slot ? (~tx_byte & (left_ff != 8'h00)) : (tx_byte & ~sh_ff[7]);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= 13'h0000;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      left_ff   <= 8'h00;
      first_ff  <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (swrst)
    begin
      st_ff     <= ST_IDLE;
      cnt_ff    <= 13'h0000;
      bit_ff    <= 4'h0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else if (en_ff)
    begin
      case (st_ff)
        ST_IDLE:
          if (go)
          begin
            sda_oe_ff <= 1'b1;
            cnt_ff    <= hi_per;
            st_ff     <= ST_START;
          end
        ST_START:
          if (cnt_ff == 13'h0000)
          begin
            scl_oe_ff <= 1'b1;
            sh_ff     <= {addr_ff, dir_ff};
            bit_ff    <= 4'h0;
            first_ff  <= 1'b1;
            left_ff   <= nbytes_ff;
            cnt_ff    <= lo_per;
            st_ff     <= ST_LOW;
          end
          else
            cnt_ff <= cnt_ff - 13'h0001;
        ST_LOW:
        begin
          // data moves one clock after the falling edge for hold time
          sda_oe_ff <= drive_low;
          if (cnt_ff == 13'h0000)
          begin
            scl_oe_ff <= 1'b0;
            cnt_ff    <= hi_per;
            st_ff     <= ST_HIGH;
          end
          else
            cnt_ff <= cnt_ff - 13'h0001;
        end
        ST_HIGH:
          // a slave holding the clock low stretches the high count
          if (scl_s2_ff)
          begin
            if (cnt_ff == 13'h0000)
            begin
              scl_oe_ff <= 1'b1;
              cnt_ff    <= lo_per;
              if (!ack_slot)
              begin
                sh_ff  <= {sh_ff[6:0], sda_s2_ff};
                bit_ff <= bit_ff + 4'h1;
                st_ff  <= ST_LOW;
              end
              else if (load_next)
              begin
                bit_ff   <= 4'h0;
                first_ff <= 1'b0;
                left_ff  <= left_ff - 8'h01;
                sh_ff    <= dir_ff ? 8'h00 : thr_ff;
                st_ff    <= ST_LOW;
              end
              else
                st_ff <= ST_STOP_LOW;
            end
            else
              cnt_ff <= cnt_ff - 13'h0001;
          end
        ST_STOP_LOW:
        begin
          sda_oe_ff <= 1'b1;
          if (cnt_ff == 13'h0000)
          begin
            scl_oe_ff <= 1'b0;
            cnt_ff    <= hi_per;
            st_ff     <= ST_STOP_HIGH;
          end
          else
            cnt_ff <= cnt_ff - 13'h0001;
        end
        ST_STOP_HIGH:
          if (scl_s2_ff)
          begin
            if (cnt_ff == 13'h0000)
            begin
              sda_oe_ff <= 1'b0;
              st_ff     <= ST_IDLE;
            end
            else
              cnt_ff <= cnt_ff - 13'h0001;
          end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; hardware set wins over a software clear

  logic       transfer_complete_flag_ff, receive_ready_flag_ff, transmit_ready_flag_ff, ovre_ff, nack_ff, pend_ff;
  logic [7:0] rhr_ff;
  wire  [4:0] w1c = wr_sr ? hwdata[4:0] : 5'h00;
  wire  [4:0] sr5 = {nack_ff, ovre_ff, transmit_ready_flag_ff, receive_ready_flag_ff, transfer_complete_flag_ff};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transfer_complete_flag_ff <= `TWM_RST_TRANSFER_COMPLETE_FLAG;
      transmit_ready_flag_ff  <= `TWM_RST_TRANSMIT_READY_FLAG;
      receive_ready_flag_ff  <= 1'b0;
      ovre_ff   <= 1'b0;
      nack_ff   <= 1'b0;
      pend_ff   <= 1'b0;
      rhr_ff    <= 8'h00;
    end
    else if (swrst)
    begin
      transfer_complete_flag_ff <= `TWM_RST_TRANSFER_COMPLETE_FLAG;
      transmit_ready_flag_ff  <= `TWM_RST_TRANSMIT_READY_FLAG;
      receive_ready_flag_ff  <= 1'b0;
      ovre_ff   <= 1'b0;
      nack_ff   <= 1'b0;
      pend_ff   <= 1'b0;
    end
    else
    begin
      // master disable has no term here, so both flags hold
      transfer_complete_flag_ff <= (transfer_complete_flag_ff & ~w1c[0] & ~go) | frame_end;
      transmit_ready_flag_ff  <= (transmit_ready_flag_ff & ~w1c[2] & ~wr_thr) | (load_next & ~dir_ff);
      receive_ready_flag_ff  <= (receive_ready_flag_ff & ~w1c[1] & ~rd_rhr) | (byte_done & ~tx_byte);
      ovre_ff   <= (ovre_ff & ~w1c[3]) | (byte_done & ~tx_byte & receive_ready_flag_ff);
      // a status read drops the pending nack before completion
      pend_ff   <= (pend_ff & ~rd_sr & ~frame_end) | (byte_done & nack_seen);
      nack_ff   <= (nack_ff & ~w1c[4] & ~rd_sr) | (frame_end & pend_ff);
      if (byte_done)
        rhr_ff <= sh_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and outputs

  logic [31:0] rdata;
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (a_ff)
      `TWM_OFS_CTRL:   rdata[`TWM_CR_MSEN] = en_ff;
      `TWM_OFS_MODE:   rdata = {8'h00, nbytes_ff, 7'h00, dir_ff, 1'b0, addr_ff};
      `TWM_OFS_CLKDIV: rdata = {13'h0000, exp_ff, hidiv_ff, lodiv_ff};
      `TWM_OFS_STATUS: rdata = {22'h000000, stuck_ff, busy, 3'h0, sr5};
      `TWM_OFS_MASK:   rdata = {27'h0000000, imr_ff};
      `TWM_OFS_RXHOLD: rdata = {24'h000000, rhr_ff};
      default:         rdata = 32'h0000_0000;
    endcase
  end

  logic irq_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff <= 32'h0000_0000;
      irq_ff    <= 1'b0;
    end
    else
    begin
      if (rd)
        hrdata_ff <= rdata;
      irq_ff <= |(sr5 & imr_ff);
    end
  end

  // low drive of the open-drain lines is a constant register
  logic zero_ff;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      zero_ff <= 1'b0;
    else
      zero_ff <= 1'b0;
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = zero_ff;
  assign scl_o     = zero_ff;
  assign sda_o     = zero_ff;
  assign scl_oe    = scl_oe_ff;
  assign sda_oe    = sda_oe_ff;
  assign irq       = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence seq_stop_done;
    frame_end;
  endsequence

  sequence seq_go;
    go;
  endsequence

  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    (!en_ff && !swrst) |=> ($stable(st_ff) && $stable(cnt_ff)))
    else $error("transfer not frozen while disabled");

  AST_DIS_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_cr && hwdata[`TWM_CR_MASTER_DISABLE_BIT] && !hwdata[`TWM_CR_SWRST] && !frame_end
     && !byte_done && !go)
    |=> (transfer_complete_flag_ff == $past(transfer_complete_flag_ff)) && (transmit_ready_flag_ff == $past(transmit_ready_flag_ff)))
    else $error("disable changed completion or transmit flags");

  AST_NACK_WITH_COMP: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(nack_ff) |-> $rose(transfer_complete_flag_ff))
    else $error("nack rose without completion");

  AST_NACK_RDCLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_sr && !frame_end) |=> !nack_ff)
    else $error("status read did not clear nack");

  AST_NACK_LOST: assert property (@(posedge hclk) disable iff (!hresetn)
    (pend_ff && rd_sr && !frame_end && !byte_done) |=> !pend_ff ##0 !nack_ff)
    else $error("early status read did not drop nack");

  AST_RHR_TX: assert property (@(posedge hclk) disable iff (!hresetn)
    (byte_done && tx_byte) |=> (rhr_ff == $past(sh_ff)))
    else $error("receive holding not loaded on transmit byte");

  AST_NO_RECEIVE_READY_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    (byte_done && tx_byte && !receive_ready_flag_ff && !ovre_ff) |=> (!receive_ready_flag_ff && !ovre_ff))
    else $error("transmit byte raised receive flags");

  AST_STUCK: assert property (@(posedge hclk) disable iff (!hresetn)
    stuck_ff |-> ##1 (st_ff == ST_IDLE) [*2])
    else $error("transfer started after stuck reset");

  AST_STOP_END: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_stop_done |=> (transfer_complete_flag_ff && !sda_oe_ff && !scl_oe_ff && st_ff == ST_IDLE))
    else $error("stop did not release lines and complete");

  AST_START_COND: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_go |=> (sda_oe_ff && !scl_oe_ff && !transfer_complete_flag_ff) ##1 (st_ff == ST_START))
    else $error("start condition malformed");

endmodule

// *** testbench/twm_slave_model.sv ***
// behavioural two-wire slave: acks its own address, takes or returns one byte
// assumes the bench resolves both pulled-up lines and feeds the levels back here
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  input  wire logic       nack_data,
  input  wire logic       stretch,
  output logic            sda_pull,
  output logic            scl_pull,
  output logic [7:0]      got_byte,
  output logic            nacked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       live = 1'b0;
  logic       rw = 1'b0;
  logic       mack = 1'b0;
  logic [7:0] sh = 8'h00;
  int         bcnt = 0;
  int         nbyte = 0;
  initial
  begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    got_byte = 8'h00;
    nacked = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // start and stop are data edges while the clock line is high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      live = 1'b1;
      // the start's own clock fall brings this to zero
      bcnt = -1;
      nbyte = 0;
      nacked = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      live = 1'b0;
  always @(posedge scl)
    if (live && bcnt < 8)
      sh = {sh[6:0], sda};
    else if (live)
      mack = ~sda;
  // changes only on clock falls, so data is stable while the clock is high
  always @(negedge scl)
    if (live)
    begin
      bcnt = bcnt + 1;
      sda_pull = 1'b0;
      if (bcnt == 8 && nbyte == 0)
      begin
        rw = sh[0] && sh[7:1] == ADDR;
        sda_pull = sh[7:1] == ADDR;
      end
      else if (bcnt == 8 && !rw)
      begin
        got_byte = sh;
        sda_pull = !nack_data;
        nacked = nack_data;
      end
      if (bcnt == 9)
      begin
        bcnt = 0;
        nbyte = nbyte + 1;
      end
      // a master nack ends the read, so no further byte is offered
      if (rw && nbyte > 0 && bcnt < 8 && (bcnt > 0 || nbyte == 1 || mack))
        sda_pull = ~rd_byte[7 - bcnt];
      if (stretch)
      begin
        scl_pull = 1'b1;
        // held past the master's low phase, so the stretch is really seen
        #900 scl_pull = 1'b0;
      end
    end
endmodule

// *** testbench/testbench.sv ***
// bench of the two-wire master: bus tasks, slave model, randomised frames
// assumes the register map header and pulled-up clock and data lines
`include "twm_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] SLV = 7'h2A; // arbitrary slave address
  localparam logic [4:0] A_CT = `TWM_OFS_CTRL, A_MD = `TWM_OFS_MODE, A_CD = `TWM_OFS_CLKDIV;
  localparam logic [4:0] A_ST = `TWM_OFS_STATUS, A_MK = `TWM_OFS_MASK;
  localparam logic [4:0] A_TX = `TWM_OFS_TXHOLD, A_RX = `TWM_OFS_RXHOLD;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, r, s1;
  logic        hrdy, hresp, scl_oe, sda_oe, irq, scl_pull, sda_pull, nacked, scl_o, sda_o;
  logic [7:0]  got_byte, b;
  logic [7:0]  rd_byte = 8'h00;
  logic        nack_data = 1'b0;
  logic        stretch = 1'b0;
  int          failures = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  wire         scl_w = ~(scl_oe | scl_pull);
  wire         sda_w = ~(sda_oe | sda_pull);

  twm_master dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
    .hreadyout(hrdy), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
  );
  twm_slave_model #(.ADDR(SLV)) slave (
    .scl(scl_w), .sda(sda_w), .rd_byte(rd_byte), .nack_data(nack_data),
    .stretch(stretch), .sda_pull(sda_pull), .scl_pull(scl_pull),
    .got_byte(got_byte), .nacked(nacked)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #50 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] st_exp(input logic c, x, t, o, k);
    return {27'h0, k, o, t, x, c};
  endfunction
  // single transfer; waits on hready with no assumed latency
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {27'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hrdy !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hrdy !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask
  task automatic frame(input logic rd, input logic [6:0] a, input logic [7:0] tx,
                       input logic [4:0] m);
    bus(1'b1, A_MK, 32'h0);
    bus(1'b1, A_MD, {16'h0001, 7'h0, rd, 1'b0, a});
    if (!rd)
      bus(1'b1, A_TX, {24'h0, tx});
    bus(1'b1, A_CT, 32'h2);
    bus(1'b1, A_CT, 32'h3);
    bus(1'b1, A_MK, {27'h0, m});
  endtask
  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(posedge hclk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(14));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, A_ST, 32'h0);
    chk("status", st_exp(1, 0, 1, 0, 0), r);
    chk("resp and line drive", 32'h0, {29'h0, hresp, scl_o, sda_o});
    bus(1'b0, A_CD, 32'h0);
    chk("clkdiv", {13'h0, `TWM_RST_EXP, `TWM_RST_HIDIV, `TWM_RST_LODIV}, r);
    s1 = $urandom & 32'h0001_0F0F;
    bus(1'b1, A_CD, s1);
    bus(1'b0, A_CD, 32'h0);
    chk("clkdiv", s1, r);
    bus(1'b1, A_CD, 32'h0000_0404);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    bus(1'b0, 5'h1C, 32'h0);
    chk("hole", 32'h0, r);
    repeat (3)
    begin
      b = 8'($urandom);
      stretch <= 1'($urandom);
      frame(1'b0, SLV, b, 5'h01);
      wait_irq();
      chk("slave byte", {24'h0, b}, {24'h0, got_byte});
      bus(1'b0, A_ST, 32'h0);
      chk("status", st_exp(1, 0, 1, 0, 0), r & 32'h1F);
      bus(1'b0, A_RX, 32'h0);
      chk("rxhold", {24'h0, b}, r);
    end
    stretch <= 1'b0;
    rd_byte <= 8'($urandom);
    frame(1'b1, SLV, 8'h00, 5'h01);
    wait_irq();
    bus(1'b0, A_ST, 32'h0);
    chk("status", st_exp(1, 1, 1, 0, 0), r & 32'h1F);
    bus(1'b0, A_RX, 32'h0);
    chk("rxhold", {24'h0, rd_byte}, r);
    frame(1'b1, SLV, 8'h00, 5'h01);
    wait_irq();
    b = 8'($urandom);
    frame(1'b0, SLV, b, 5'h01);
    wait_irq();
    bus(1'b0, A_ST, 32'h0);
    chk("status", st_exp(1, 1, 1, 0, 0), r & 32'h1F);
    bus(1'b0, A_RX, 32'h0);
    chk("rxhold", {24'h0, b}, r);
    for (int i = 0; i < 2; i++)
    begin
      nack_data <= (i == 1);
      frame(1'b0, (i == 0) ? ~SLV : SLV, 8'h5A, 5'h10);
      wait_irq();
      bus(1'b0, A_ST, 32'h0);
      chk("nack", 32'h11, r & 32'h11);
      bus(1'b0, A_ST, 32'h0);
      chk("nack read", 32'h01, r & 32'h11);
    end
    frame(1'b0, SLV, 8'hC3, 5'h01);
    @(posedge nacked);
    @(negedge scl_w);
    bus(1'b0, A_ST, 32'h0);
    chk("early read", 32'h0, r & 32'h11);
    wait_irq();
    bus(1'b0, A_ST, 32'h0);
    chk("nack lost", 32'h01, r & 32'h11);
    nack_data <= 1'b0;
    frame(1'b0, SLV, 8'h96, 5'h01);
    repeat (30) @(posedge hclk);
    bus(1'b0, A_ST, 32'h0);
    s1 = r;
    bus(1'b1, A_CT, 32'h4);
    b = {6'h0, scl_oe, sda_oe};
    n = 0;
    repeat (40)
    begin
      @(posedge hclk);
      n += int'({scl_oe, sda_oe} !== b[1:0]);
    end
    chk("frozen", 32'h0, n);
    bus(1'b0, A_ST, 32'h0);
    chk("flags kept", s1 & 32'h5, r & 32'h5);
    bus(1'b1, A_CT, 32'h2);
    wait_irq();
    chk("resumed", 32'h96, {24'h0, got_byte});
    bus(1'b1, A_MK, 32'h0);
    repeat (2) @(posedge hclk);
    chk("masked irq", 32'h0, {31'h0, irq});
    bus(1'b1, A_CT, 32'h4);
    bus(1'b0, A_ST, 32'h0);
    chk("idle flags kept", 32'h5, r & 32'h5);
    bus(1'b1, A_MK, 32'h1);
    bus(1'b1, A_ST, 32'h1);
    repeat (2) @(posedge hclk);
    chk("cleared irq", 32'h0, {31'h0, irq});
    frame(1'b0, SLV, 8'h3C, 5'h00);
    @(negedge scl_w);
    bus(1'b1, A_CT, 32'h80);
    bus(1'b0, A_ST, 32'h0);
    chk("stuck", 32'h200, r & 32'h200);
    frame(1'b0, SLV, 8'h3C, 5'h00);
    n = 0;
    repeat (100)
    begin
      @(posedge hclk);
      n += int'(sda_oe !== 1'b0);
    end
    chk("no start", 32'h0, n);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    frame(1'b0, SLV, 8'hE1, 5'h01);
    wait_irq();
    chk("after reset", 32'hE1, {24'h0, got_byte});
    end_sim();
  end
endmodule
